// ### cell_sync_frame_timing.sv
// Cell frame counter, slewed timing, late-entrant search and report strobe.
// Assumes controller messages arrive as one-cycle pulses on this clock.
`timescale 1ns/1ps
module cell_sync_frame_timing (
  input  wire logic                                  clk_i,
  input  wire logic                                  rst_i,
  input  wire logic                                  ref_locked_i,
  input  wire logic                                  epoch_pulse_i,
  input  wire logic [frame_timing_pkg::SFN_W-1:0]    port_count_i,
  input  wire logic [frame_timing_pkg::SFN_W-1:0]    ref_offset_i,
  input  wire logic                                  count_update_i,
  input  wire logic [frame_timing_pkg::SFN_W-1:0]    count_update_val_i,
  input  wire logic                                  init_start_i,
  input  wire logic                                  late_start_i,
  input  wire logic [frame_timing_pkg::SFN_W-1:0]    late_frame_i,
  input  wire logic                                  reconfig_i,
  input  wire frame_timing_pkg::sched_t              sched_i,
  input  wire logic                                  adjust_i,
  input  wire frame_timing_pkg::adjust_t             adjust_data_i,
  input  wire logic                                  detect_i,
  input  wire logic [7:0]                            detect_quality_i,
  output logic [frame_timing_pkg::SFN_W-1:0]         cell_frame_count_o,
  output logic                                       frame_start_o,
  output logic                                       downlink_sync_code_tx_o,
  output logic                                       sync_slot_o,
  output logic                                       traffic_en_o,
  output logic                                       adjust_ack_o,
  output logic                                       report_valid_o,
  output frame_timing_pkg::report_t                  report_o
);
  localparam int unsigned FC = frame_timing_pkg::FRAME_CYCLES;

  // Synchronised pin inputs
  logic [1:0] epoch_s_r;
  logic [1:0] epoch_s_nxt;
  logic [1:0] det_s_r;
  logic [1:0] det_s_nxt;
  logic       epoch_q_r;
  logic       epoch_q_nxt;

  always_comb begin
    epoch_s_nxt = {epoch_s_r[0], epoch_pulse_i};
    det_s_nxt   = {det_s_r[0], detect_i};
    epoch_q_nxt = epoch_s_r[1];
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      epoch_s_r <= 2'h0;
      det_s_r   <= 2'h0;
      epoch_q_r <= 1'b0;
    end else begin
      epoch_s_r <= epoch_s_nxt;
      det_s_r   <= det_s_nxt;
      epoch_q_r <= epoch_q_nxt;
    end
  end

  wire epoch_rise = epoch_s_r[1] & ~epoch_q_r;
  wire det_pulse  = det_s_r[1];

  // Frame timing state
  frame_timing_pkg::phase_t                   phase_r, phase_nxt;
  logic [frame_timing_pkg::PHASE_W-1:0]       ph_r, ph_nxt;
  logic [frame_timing_pkg::SFN_W-1:0]         cnt_r, cnt_nxt;
  logic                                       fs_r, fs_nxt;
  logic signed [frame_timing_pkg::ADJ_W-1:0]  rem_r, rem_nxt;
  logic                                       pend_r, pend_nxt;
  frame_timing_pkg::adjust_t                  adj_r, adj_nxt;
  logic                                       ack_r, ack_nxt;
  logic [frame_timing_pkg::PHASE_W-1:0]       best_ph_r, best_ph_nxt;
  logic [frame_timing_pkg::SFN_W-1:0]         best_fr_r, best_fr_nxt;
  logic                                       best_v_r, best_v_nxt;
  logic [frame_timing_pkg::SFN_W-1:0]         late_fr_r, late_fr_nxt;
  logic                                       rep_v_r, rep_v_nxt;
  frame_timing_pkg::report_t                  rep_r, rep_nxt;
  logic                                       tx_r, tx_nxt;
  logic                                       slot_hit;
  logic                                       slot_r;

  sync_frame_calc u_calc (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .sched_i (sched_i),
    .count_i (cnt_r),
    .hit_o   (slot_hit)
  );

  function automatic logic in_window(input logic [frame_timing_pkg::SFN_W-1:0] f,
                                     input logic [frame_timing_pkg::SFN_W-1:0] c);
    logic [frame_timing_pkg::SFN_W-1:0] d;
    d = frame_timing_pkg::SFN_W'(f - c + frame_timing_pkg::SEARCH_HALF);
    return d <= frame_timing_pkg::SFN_W'(2 * frame_timing_pkg::SEARCH_HALF);
  endfunction

  // Phase shift by whole samples, wrapped into one frame
  function automatic logic [frame_timing_pkg::PHASE_W-1:0] shift_phase(
      input logic [frame_timing_pkg::PHASE_W-1:0] p,
      input logic signed [frame_timing_pkg::ADJ_W-1:0] s);
    int t;
    t = int'(p) + int'(s) * int'(frame_timing_pkg::SAMPLE_CYCLES);
    if (t < 0) begin
      t = t + int'(FC);
    end else if (t >= int'(FC)) begin
      t = t - int'(FC);
    end
    return frame_timing_pkg::PHASE_W'(t);
  endfunction

  wire frame_end = (ph_r == frame_timing_pkg::PHASE_W'(FC - 1));
  wire ref_cell  = ref_locked_i;

  always_comb begin
    phase_nxt   = phase_r;
    ph_nxt      = frame_end ? '0 : ph_r + 1'b1;
    cnt_nxt     = frame_end ? cnt_r + 1'b1 : cnt_r;
    fs_nxt      = frame_end;
    rem_nxt     = rem_r;
    pend_nxt    = pend_r;
    adj_nxt     = adj_r;
    ack_nxt     = 1'b0;
    best_ph_nxt = best_ph_r;
    best_fr_nxt = best_fr_r;
    best_v_nxt  = best_v_r;
    late_fr_nxt = late_fr_r;
    rep_v_nxt   = 1'b0;
    rep_nxt     = rep_r;
    tx_nxt      = tx_r;

    if (ref_cell && epoch_rise) begin
      ph_nxt  = '0;
      cnt_nxt = frame_timing_pkg::SFN_W'(port_count_i + ref_offset_i);
      fs_nxt  = 1'b1;
    end else if (count_update_i && !ref_cell) begin
      ph_nxt  = '0;
      cnt_nxt = count_update_val_i;
      fs_nxt  = 1'b1;
    end

    if (adjust_i) begin
      adj_nxt  = adjust_data_i;
      pend_nxt = 1'b1;
      if (phase_r == frame_timing_pkg::PHASE_INITIAL) begin
        // Immediate shift so ack follows completion
        ph_nxt  = shift_phase(ph_r, adjust_data_i.samples);
        pend_nxt = 1'b0;
        ack_nxt  = 1'b1;
      end
    end else if (pend_r && frame_end && cnt_nxt == adj_r.start_frame) begin
      rem_nxt  = adj_r.samples;
      pend_nxt = 1'b0;
    end

    // One sample per frame at frame start
    if (frame_end && rem_r != 0 && !(pend_r && cnt_nxt == adj_r.start_frame)) begin
      if (rem_r > 0) begin
        ph_nxt  = frame_timing_pkg::PHASE_W'(frame_timing_pkg::SAMPLE_CYCLES);
        rem_nxt = rem_r - 1'b1;
      end else begin
        ph_nxt  = frame_timing_pkg::PHASE_W'(FC - frame_timing_pkg::SAMPLE_CYCLES);
        cnt_nxt = cnt_r;
        fs_nxt  = 1'b0;
        rem_nxt = rem_r + 1'b1;
      end
      if (rem_nxt == 0) begin
        ack_nxt = 1'b1;
      end
    end

    unique case (phase_r)
      frame_timing_pkg::PHASE_IDLE: begin
        tx_nxt = 1'b0;
        if (init_start_i) begin
          phase_nxt = frame_timing_pkg::PHASE_INITIAL;
        end else if (late_start_i) begin
          phase_nxt   = frame_timing_pkg::PHASE_LATE_SEARCH;
          late_fr_nxt = late_frame_i;
          best_v_nxt  = 1'b0;
        end
      end
      frame_timing_pkg::PHASE_INITIAL: begin
        tx_nxt = 1'b1;
        if (det_pulse) begin
          rep_v_nxt = 1'b1;
          rep_nxt   = '{frame: cnt_r, phase: ph_r, quality: detect_quality_i};
        end
        if (reconfig_i) begin
          phase_nxt = frame_timing_pkg::PHASE_STEADY;
          tx_nxt    = 1'b0;
        end
      end
      frame_timing_pkg::PHASE_LATE_SEARCH: begin
        tx_nxt = 1'b0;
        if (det_pulse && in_window(cnt_r, late_fr_r) && !best_v_r) begin
          best_v_nxt  = 1'b1;
          best_ph_nxt = ph_r;
          best_fr_nxt = late_fr_r;
        end
        if (best_v_r && !in_window(cnt_r, late_fr_r)) begin
          // Earliest arrival marks start of a frame; the count is kept at cnt_r
          ph_nxt     = frame_timing_pkg::PHASE_W'(ph_r - best_ph_r);
          cnt_nxt    = frame_timing_pkg::SFN_W'(cnt_r - best_fr_r + late_fr_r);
          best_v_nxt = 1'b0;
        end
        if (reconfig_i) begin
          phase_nxt = frame_timing_pkg::PHASE_STEADY;
        end
      end
      frame_timing_pkg::PHASE_STEADY: begin
        tx_nxt = fs_r & slot_hit;
        if (det_pulse && slot_r) begin
          rep_v_nxt = 1'b1;
          rep_nxt   = '{frame: cnt_r, phase: ph_r, quality: detect_quality_i};
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase_r   <= frame_timing_pkg::PHASE_IDLE;
      ph_r      <= '0;
      cnt_r     <= frame_timing_pkg::SFN_RESET;
      fs_r      <= 1'b0;
      rem_r     <= '0;
      pend_r    <= 1'b0;
      adj_r     <= '0;
      ack_r     <= 1'b0;
      best_ph_r <= '0;
      best_fr_r <= '0;
      best_v_r  <= 1'b0;
      late_fr_r <= '0;
      rep_v_r   <= 1'b0;
      rep_r     <= '0;
      tx_r      <= 1'b0;
      slot_r    <= 1'b0;
    end else begin
      phase_r   <= phase_nxt;
      ph_r      <= ph_nxt;
      cnt_r     <= cnt_nxt;
      fs_r      <= fs_nxt;
      rem_r     <= rem_nxt;
      pend_r    <= pend_nxt;
      adj_r     <= adj_nxt;
      ack_r     <= ack_nxt;
      best_ph_r <= best_ph_nxt;
      best_fr_r <= best_fr_nxt;
      best_v_r  <= best_v_nxt;
      late_fr_r <= late_fr_nxt;
      rep_v_r   <= rep_v_nxt;
      rep_r     <= rep_nxt;
      tx_r      <= tx_nxt;
      slot_r    <= slot_hit & (phase_r == frame_timing_pkg::PHASE_STEADY);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      traffic_en_o <= 1'b0;
    end else begin
      traffic_en_o <= (phase_nxt == frame_timing_pkg::PHASE_STEADY);
    end
  end

  assign cell_frame_count_o      = cnt_r;
  assign frame_start_o           = fs_r;
  assign downlink_sync_code_tx_o = tx_r;
  assign sync_slot_o             = slot_r;
  assign adjust_ack_o            = ack_r;
  assign report_valid_o          = rep_v_r;
  assign report_o                = rep_r;
endmodule // cell_sync_frame_timing

// ### cell_sync_frame_timing_test.sv
// Self-checking bench for cell frame timing against a controller model.
// Assumes a 100 MHz clock; no frame end falls inside the run.
`timescale 1ns/1ps
module cell_sync_frame_timing_test;
  logic                              clk_i = 1'b0;
  logic                              rst_i = 1'b1;
  logic                              ref_locked_i = 1'b1;
  logic                              epoch_pulse_i = 1'b0;
  logic                              detect_i = 1'b0;
  logic [7:0]                        detect_quality_i = 8'h00;
  logic [11:0]                       port_count_i = 12'h000;
  logic [11:0]                       ref_offset_i = 12'h000;
  logic [11:0]                       want = 12'h000;
  logic [31:0]                       rnd = 32'h00000062;
  logic                              init_start_i, late_start_i, reconfig_i, adjust_i, count_update_i;
  logic [11:0]                       late_frame_i, count_update_val_i, cell_frame_count_o;
  frame_timing_pkg::sched_t          sched_i;
  frame_timing_pkg::adjust_t         adjust_data_i;
  logic                              frame_start_o, downlink_sync_code_tx_o, sync_slot_o;
  logic                              traffic_en_o, adjust_ack_o, report_valid_o;
  frame_timing_pkg::report_t         report_o;
  int                                mismatches = 0;
  int                                num_checks = 0;
  int                                c, r;
  always #5 clk_i = ~clk_i;
  controller_model ctl_u (.clk_i(clk_i), .init_start_o(init_start_i), .late_start_o(late_start_i),
    .late_frame_o(late_frame_i), .reconfig_o(reconfig_i), .sched_o(sched_i), .adjust_o(adjust_i),
    .adjust_data_o(adjust_data_i), .count_update_o(count_update_i), .count_update_val_o(count_update_val_i));
  cell_sync_frame_timing dut_u (.clk_i(clk_i), .rst_i(rst_i), .ref_locked_i(ref_locked_i),
    .epoch_pulse_i(epoch_pulse_i), .port_count_i(port_count_i), .ref_offset_i(ref_offset_i),
    .count_update_i(count_update_i), .count_update_val_i(count_update_val_i), .init_start_i(init_start_i),
    .late_start_i(late_start_i), .late_frame_i(late_frame_i), .reconfig_i(reconfig_i), .sched_i(sched_i),
    .adjust_i(adjust_i), .adjust_data_i(adjust_data_i), .detect_i(detect_i), .detect_quality_i(detect_quality_i),
    .cell_frame_count_o(cell_frame_count_o), .frame_start_o(frame_start_o),
    .downlink_sync_code_tx_o(downlink_sync_code_tx_o), .sync_slot_o(sync_slot_o), .traffic_en_o(traffic_en_o),
    .adjust_ack_o(adjust_ack_o), .report_valid_o(report_valid_o), .report_o(report_o));
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // Exact integer form of the floor, so fractional periods never round wrong
  function automatic logic sync_expect(input int cy, input int rp, input int f);
    for (int k = 0; k < cy; k++)
      for (int i = 0; i < rp; i++)
        if ((k * 4096 * rp + i * 4096) / (cy * rp) == f)
          return 1'b1;
    return 1'b0;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic cmp_val(input logic [11:0] got, input logic [11:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_val({11'h000, got}, {11'h000, exp});
  endtask
  // Bounded wait on count match, sync code, traffic, slot or report
  task automatic wait_on(input int sel, input logic v);
    logic got;
    for (int n = 0; n < 40; n++) begin
      case (sel)
        0: got = (cell_frame_count_o === want);
        1: got = downlink_sync_code_tx_o;
        2: got = traffic_en_o;
        3: got = sync_slot_o;
        default: got = report_valid_o;
      endcase
      if (got === v)
        return;
      tick(1);
    end
    mismatches++;
    wrap_up();
  endtask
  task automatic epoch();
    epoch_pulse_i = 1'b1;
    tick(2);
    epoch_pulse_i = 1'b0;
  endtask
  initial begin
    tick(12);
    rst_i = 1'b0;
    tick(1);
    cmp_val(cell_frame_count_o, 12'h000);
    cmp_bit(traffic_en_o, 1'b0);
    for (int j = 0; j < 4; j++) begin
      rnd = xorshift(rnd);
      port_count_i = j == 0 ? 12'hfff : j == 1 ? 12'h800 : rnd[11:0];
      ref_offset_i = j == 0 ? 12'h002 : j == 1 ? 12'h800 : rnd[23:12];
      want = port_count_i + ref_offset_i;
      epoch();
      wait_on(0, 1'b1);
      cmp_val(cell_frame_count_o, want);
      tick(4);
    end
    ctl_u.strobe(3, {16'h0000, ~want});
    tick(4);
    cmp_val(cell_frame_count_o, want);
    ref_locked_i = 1'b0;
    for (int j = 0; j < 3; j++) begin
      rnd = xorshift(rnd);
      want = j == 0 ? 12'hfff : rnd[11:0];
      ctl_u.strobe(3, {16'h0000, want});
      wait_on(0, 1'b1);
      cmp_val(cell_frame_count_o, want);
    end
    epoch();
    tick(6);
    cmp_val(cell_frame_count_o, want);
    ctl_u.strobe(0, 28'h0000000);
    wait_on(1, 1'b1);
    cmp_bit(downlink_sync_code_tx_o, 1'b1);
    cmp_bit(traffic_en_o, 1'b0);
    for (int j = 0; j < 3; j++) begin
      rnd = xorshift(rnd);
      ctl_u.strobe(2, rnd[27:0]);
      cmp_bit(adjust_ack_o, 1'b1);
      tick(1);
      cmp_bit(adjust_ack_o, 1'b0);
      detect_quality_i = rnd[31:24];
      detect_i = 1'b1;
      wait_on(4, 1'b1);
      cmp_val({4'h0, report_o.quality}, {4'h0, rnd[31:24]});
      detect_i = 1'b0;
      tick(4);
    end
    ctl_u.strobe(1, 28'h0000000);
    wait_on(2, 1'b1);
    cmp_bit(traffic_en_o, 1'b1);
    for (int j = 0; j < 12; j++) begin
      rnd = xorshift(rnd);
      c = j == 0 ? 1 : j == 1 ? 3 : int'(rnd[2:0]) + 1;
      r = j == 0 ? 4 : j == 1 ? 16 : int'(rnd[6:3]) + 1;
      want = 12'((int'(rnd[10:8]) % c * 4096 * r + int'(rnd[14:11]) % r * 4096) / (c * r) + int'(rnd[15]));
      ctl_u.strobe(4, {4'h0, 12'(c), 12'(r)});
      ctl_u.strobe(3, {16'h0000, want});
      wait_on(0, 1'b1);
      wait_on(3, sync_expect(c, r, int'(want)));
      cmp_bit(sync_slot_o, sync_expect(c, r, int'(want)));
    end
    ctl_u.strobe(2, {rnd[15:1], 1'b1, cell_frame_count_o + 12'h005});
    for (int j = 0; j < 8; j++) begin
      cmp_bit(adjust_ack_o, 1'b0);
      tick(1);
    end
    rst_i = 1'b1;
    tick(2);
    rst_i = 1'b0;
    tick(1);
    cmp_bit(traffic_en_o, 1'b0);
    ctl_u.strobe(5, {16'h0000, cell_frame_count_o});
    ctl_u.strobe(1, 28'h0000000);
    wait_on(2, 1'b1);
    cmp_bit(traffic_en_o, 1'b1);
    wrap_up();
  end
endmodule // cell_sync_frame_timing_test

// ### controller_model.sv
// Network controller model: phase commands, schedules and adjustments.
// Assumes the cell takes each one-cycle command on the rising edge.
`timescale 1ns/1ps
module controller_model (
  input  wire logic                  clk_i,
  output logic                       init_start_o,
  output logic                       late_start_o,
  output logic [11:0]                late_frame_o,
  output logic                       reconfig_o,
  output frame_timing_pkg::sched_t   sched_o,
  output logic                       adjust_o,
  output frame_timing_pkg::adjust_t  adjust_data_o,
  output logic                       count_update_o,
  output logic [11:0]                count_update_val_o
);
  initial begin
    {init_start_o, late_start_o, reconfig_o, adjust_o, count_update_o} = 5'h00;
    late_frame_o = 12'h000;
    sched_o = 24'h001001;
    adjust_data_o = 28'h0000000;
    count_update_val_o = 12'h000;
  end
  // Command 0 init, 1 reconfig, 2 adjust, 3 count update, 4 schedule level
  task automatic strobe(input int sel, input logic [27:0] data);
    @(posedge clk_i);
    #1;
    case (sel)
      0: init_start_o = 1'b1;
      1: reconfig_o = 1'b1;
      2: begin
        adjust_data_o = data;
        adjust_o = 1'b1;
      end
      3: begin
        count_update_val_o = data[11:0];
        count_update_o = 1'b1;
      end
      5: begin
        late_frame_o = data[11:0];
        late_start_o = 1'b1;
      end
      default: sched_o = data[23:0];
    endcase
    @(posedge clk_i);
    #1;
    {init_start_o, late_start_o, reconfig_o, adjust_o, count_update_o} = 5'h00;
  endtask
endmodule // controller_model

// ### frame_timing_monitor.sv
// Checker for cell frame timing, bound onto the top module.
// Assumes one clock domain with asynchronous active-high reset.
`timescale 1ns/1ps
module frame_timing_monitor (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ref_locked_i,
  input wire logic        epoch_pulse_i,
  input wire logic [11:0] port_count_i,
  input wire logic [11:0] ref_offset_i,
  input wire logic        count_update_i,
  input wire logic [11:0] count_update_val_i,
  input wire logic        init_start_i,
  input wire logic        reconfig_i,
  input wire logic        adjust_i,
  input wire logic        detect_i,
  input wire logic [11:0] cell_frame_count_o,
  input wire logic        downlink_sync_code_tx_o,
  input wire logic        sync_slot_o,
  input wire logic        traffic_en_o,
  input wire logic        adjust_ack_o,
  input wire logic        report_valid_o
);
  logic        init_r;
  logic        init_nxt;
  logic [11:0] sum_w;
  assign sum_w = port_count_i + ref_offset_i;
  always_comb begin
    init_nxt = init_r;
    if (init_start_i)
      init_nxt = 1'b1;
    if (reconfig_i)
      init_nxt = 1'b0;
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i)
      init_r <= 1'b0;
    else
      init_r <= init_nxt;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  reset_clear_a:
    assert property ($fell(rst_i) |-> cell_frame_count_o == 12'h000 && !traffic_en_o && !adjust_ack_o)
      else $error("outputs not clear after reset");
  epoch_load_a:
    assert property (ref_locked_i && $rose(epoch_pulse_i) |-> ##[1:6] cell_frame_count_o == sum_w)
      else $error("count not loaded at epoch");
  update_load_a:
    assert property (!ref_locked_i && count_update_i |-> ##[1:4] cell_frame_count_o == count_update_val_i)
      else $error("count update not applied");
  update_refuse_a:
    assert property (ref_locked_i && count_update_i |=> $stable(cell_frame_count_o) [*3])
      else $error("locked cell took count update");
  init_ack_a:
    assert property (init_r && adjust_i |=> adjust_ack_o)
      else $error("initial adjust not acknowledged");
  init_quiet_a:
    assert property (init_r |-> !traffic_en_o)
      else $error("traffic during initial phase");
  init_tx_a:
    assert property (init_start_i |-> ##[1:3] downlink_sync_code_tx_o)
      else $error("sync code not sent in initial phase");
  report_lat_a:
    assert property (init_r && $rose(detect_i) |-> ##[2:4] report_valid_o)
      else $error("detection not reported");
  steady_wait_a:
    assert property (traffic_en_o && adjust_i |=> !adjust_ack_o [*8])
      else $error("steady adjust acknowledged early");
  cover property (ref_locked_i && $rose(epoch_pulse_i));
  cover property (init_r && adjust_ack_o);
  cover property (report_valid_o);
  cover property (traffic_en_o && sync_slot_o);
endmodule // frame_timing_monitor

bind cell_sync_frame_timing frame_timing_monitor mon_u (
  .clk_i(clk_i), .rst_i(rst_i), .ref_locked_i(ref_locked_i), .epoch_pulse_i(epoch_pulse_i),
  .port_count_i(port_count_i), .ref_offset_i(ref_offset_i), .count_update_i(count_update_i),
  .count_update_val_i(count_update_val_i), .init_start_i(init_start_i), .reconfig_i(reconfig_i),
  .adjust_i(adjust_i), .detect_i(detect_i), .cell_frame_count_o(cell_frame_count_o),
  .downlink_sync_code_tx_o(downlink_sync_code_tx_o), .sync_slot_o(sync_slot_o),
  .traffic_en_o(traffic_en_o), .adjust_ack_o(adjust_ack_o), .report_valid_o(report_valid_o)
);

// ### frame_timing_pkg.sv
// Package for cell frame timing: constants and carrier structs.
// Assumes a single 100 MHz clock and a frame strobe derived internally.
package frame_timing_pkg;
  localparam int unsigned CLK_HZ           = 100_000_000;
  localparam int unsigned FRAME_NS         = 10_000_000;
  localparam int unsigned FRAME_CYCLES     = FRAME_NS / (1_000_000_000 / CLK_HZ);
  localparam int unsigned SAMPLE_CYCLES    = 16;
  localparam int unsigned SFN_PERIOD       = 4096;
  localparam int unsigned SFN_W            = 12;
  localparam int unsigned PHASE_W          = 20;
  localparam int unsigned FRAC_W           = 12;
  localparam int unsigned ADJ_W            = 16;
  localparam logic [SFN_W-1:0] SEARCH_HALF = 12'h003;
  localparam logic [SFN_W-1:0] SFN_RESET   = 12'h000;

  typedef enum logic [1:0] {
    PHASE_IDLE,
    PHASE_INITIAL,
    PHASE_LATE_SEARCH,
    PHASE_STEADY
  } phase_t;

  typedef struct packed {
    logic [SFN_W-1:0] cycles;
    logic [SFN_W-1:0] reps;
  } sched_t;

  typedef struct packed {
    logic signed [ADJ_W-1:0] samples;
    logic [SFN_W-1:0]        start_frame;
  } adjust_t;

  typedef struct packed {
    logic [SFN_W-1:0]   frame;
    logic [PHASE_W-1:0] phase;
    logic [7:0]         quality;
  } report_t;
endpackage

// ### sync_frame_calc.sv
// Synchronisation frame test for the current frame count.
// Assumes schedule values stable while in steady state.
`timescale 1ns/1ps
module sync_frame_calc (
  input  wire logic                                  clk_i,
  input  wire logic                                  rst_i,
  input  wire frame_timing_pkg::sched_t              sched_i,
  input  wire logic [frame_timing_pkg::SFN_W-1:0]    count_i,
  output logic                                       hit_o
);
  localparam int unsigned W = 48;

  // Exact integer floor, so fractional periods never land one frame off
  function automatic logic [W-1:0] sync_frame(input logic [W-1:0] k, input logic [W-1:0] n,
                                              input logic [W-1:0] cy, input logic [W-1:0] rp);
    return (k * rp * W'(frame_timing_pkg::SFN_PERIOD) + n * W'(frame_timing_pkg::SFN_PERIOD)) / (cy * rp);
  endfunction

  logic [W-1:0]                         cy;
  logic [W-1:0]                         rp;
  logic [W-1:0]                         k0;
  logic [W-1:0]                         kk;
  logic                                 hit_nxt;
  logic                                 hit_r;

  always_comb begin
    cy      = (sched_i.cycles == '0) ? W'(1) : W'(sched_i.cycles);
    rp      = (sched_i.reps == '0) ? W'(1) : W'(sched_i.reps);
    k0      = (W'(count_i) * cy) / W'(frame_timing_pkg::SFN_PERIOD);
    kk      = '0;
    hit_nxt = 1'b0;
    // Candidate cycle is k0 or the next one when cycle length is fractional
    for (int d = 0; d < 2; d++) begin
      kk = k0 + W'(d);
      for (int n = 0; n < 16; n++) begin
        if (kk < cy && W'(n) < rp && sync_frame(kk, W'(n), cy, rp) == W'(count_i)) begin
          hit_nxt = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hit_r <= 1'b0;
    end else begin
      hit_r <= hit_nxt;
    end
  end

  assign hit_o = hit_r;
endmodule // sync_frame_calc
